// file: verilog/cfd_pkg.sv
// Constants, encodings and register map for the control-flow decoder.
// Assumes a 16-bit instruction word and a 21-bit byte program counter.
`default_nettype none
package cfd_pkg;
   // ==========================================================
   // Widths
   localparam int PC_W = 21;
   localparam int INSTR_W = 16;
   localparam int PORT_W = 8;
   localparam int FILE_ADDR_W = 12;
   // ==========================================================
   // Opcode fields
   localparam logic [4:0] OP_COND_BRANCH = 5'h1C;
   localparam logic [4:0] OP_REL_JUMP = 5'h1A;
   localparam logic [4:0] OP_REL_CALL = 5'h1B;
   localparam logic [7:0] OP_ABS_JUMP = 8'hEF;
   localparam logic [6:0] OP_ABS_CALL = 7'h76;
   localparam logic [3:0] OP_SECOND_WORD = 4'hF;
   localparam logic [7:0] OP_LIT_RETURN = 8'h0C;
   localparam logic [15:0] OP_POP = 16'h0006;
   localparam logic [15:0] OP_PUSH = 16'h0005;
   localparam logic [14:0] OP_IRQ_RETURN = 15'h0008;
   localparam logic [14:0] OP_SUB_RETURN = 15'h0009;
   localparam logic [15:0] OP_STANDBY = 16'h0003;
   localparam logic [15:0] OP_WDT_CLEAR = 16'h0004;
   localparam logic [15:0] OP_DEC_ADJUST = 16'h0007;
   localparam logic [15:0] OP_SOFT_RESET = 16'h00FF;
   localparam logic [13:0] OP_TABLE_WRITE = 14'h0003;
   // ==========================================================
   // Branch conditions
   localparam logic [2:0] CC_ZERO = 3'h0;
   localparam logic [2:0] CC_NOT_ZERO = 3'h1;
   localparam logic [2:0] CC_CARRY = 3'h2;
   localparam logic [2:0] CC_NOT_CARRY = 3'h3;
   localparam logic [2:0] CC_OVF = 3'h4;
   localparam logic [2:0] CC_NOT_OVF = 3'h5;
   localparam logic [2:0] CC_NEG = 3'h6;
   localparam logic [2:0] CC_NOT_NEG = 3'h7;
   // ==========================================================
   // Timer zero count register file address
   localparam logic [FILE_ADDR_W-1:0] TIMER_ZERO_ADDR = 12'hFD6;
   // ==========================================================
   // Register map (byte offsets) and reset values
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_COUNT = 4'h8;
   localparam int CTRL_PRESCALER_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam int STAT_TIMEOUT_BIT = 0;
   localparam int STAT_PDOWN_BIT = 1;
   localparam int STAT_PWRITE_BIT = 2;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_CYCLES_LSB = 8;
   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {ST_EXEC, ST_WORD2, ST_FLUSH} cfd_state_t;
endpackage
`default_nettype wire

// file: verilog/cfd_ctl_if.sv
// Configuration and status carried between the decoder core and its registers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cfd_ctl_if;
   logic prescaler_assigned;
   logic decode_enable;
   logic timeout_flag;
   logic power_down_flag;
   logic prog_write;
   logic [1:0] state_code;
   logic [1:0] last_cycles;
   logic [15:0] instr_count;
   modport regs (
      output prescaler_assigned, decode_enable,
      input timeout_flag, power_down_flag, prog_write, state_code, last_cycles, instr_count
   );
   modport core (
      input prescaler_assigned, decode_enable,
      output timeout_flag, power_down_flag, prog_write, state_code, last_cycles, instr_count
   );
endinterface
`default_nettype wire

// file: verilog/cfd_pin_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes the pins change with no relation to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module cfd_pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;
   // ==========================================================
   // Synchroniser stages
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule // cfd_pin_sync
`default_nettype wire

// file: verilog/cfd_avmm_regs.sv
// Avalon-MM slave with control, status and count registers.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module cfd_avmm_regs (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   cfd_ctl_if.regs ctl
);
   logic [1:0] ctrl_r;
   logic req;
   assign req = avs_read_i | avs_write_i;
   assign ctl.prescaler_assigned = ctrl_r[cfd_pkg::CTRL_PRESCALER_BIT];
   assign ctl.decode_enable = ctrl_r[cfd_pkg::CTRL_ENABLE_BIT];
   // ==========================================================
   // Handshake: one wait cycle, then accept
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !(req && avs_waitrequest_o);
      end
   end
   // ==========================================================
   // Read data, unmapped reads as zero
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         avs_readdata_o <= '0;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= '0;
         case (avs_address_i)
            cfd_pkg::REG_CTRL: avs_readdata_o[1:0] <= ctrl_r;
            cfd_pkg::REG_STATUS: begin
               avs_readdata_o[cfd_pkg::STAT_TIMEOUT_BIT] <= ctl.timeout_flag;
               avs_readdata_o[cfd_pkg::STAT_PDOWN_BIT] <= ctl.power_down_flag;
               avs_readdata_o[cfd_pkg::STAT_PWRITE_BIT] <= ctl.prog_write;
               avs_readdata_o[cfd_pkg::STAT_STATE_LSB +: 2] <= ctl.state_code;
               avs_readdata_o[cfd_pkg::STAT_CYCLES_LSB +: 2] <= ctl.last_cycles;
            end
            cfd_pkg::REG_COUNT: avs_readdata_o[15:0] <= ctl.instr_count;
            default: avs_readdata_o <= '0;
         endcase
      end
   end
   // ==========================================================
   // Control register write
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ctrl_r <= cfd_pkg::CTRL_RESET;
      end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == cfd_pkg::REG_CTRL) begin
         ctrl_r <= avs_writedata_i[1:0];
      end
   end
endmodule // cfd_avmm_regs
`default_nettype wire

// file: verilog/cfd_decoder.sv
// Control-flow instruction decoder and sequencer.
// Assumes a fetch unit that presents one word per valid cycle and refetches on pc_load_o.
// Operation
// - A word 1110 0ccc is a conditional branch with an 8-bit signed word offset.
// - The condition code selects zero, carry, overflow or negative, plain or inverted.
// - A taken branch or a program counter change takes two cycles, the second a no-op.
// - The absolute jump is two words giving a 20-bit target in two cycles.
// - Any word starting 1111 fetched on its own is a one-cycle no-op.
// - Word 0x0006 discards the stack top in one cycle.
// - Word 0x0005 pushes the next instruction address in one cycle.
// - Word 0x001s returns from interrupt in two cycles and re-enables interrupts.
// - Word 0x0Ckk loads the literal into the working register and returns.
// - Word 0x0003 enters standby and updates the timeout and power-down flags.
// - A file write to the timer zero count clears its prescaler when assigned.
// - Port read-modify-write reads the pin levels, not the output latch.
// - A started program memory table write runs until terminated.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cfd_decoder (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [15:0] instr_word_i,
   input wire logic instr_valid_i,
   input wire logic [20:0] next_pc_i,
   input wire logic [20:0] stack_top_entry_i,
   input wire logic flag_zero_i,
   input wire logic flag_carry_i,
   input wire logic flag_ovf_i,
   input wire logic flag_neg_i,
   input wire logic file_write_i,
   input wire logic [11:0] file_addr_i,
   input wire logic dest_file_i,
   input wire logic [7:0] port_pins_i,
   input wire logic prog_write_done_i,
   output logic pc_load_o,
   output logic [20:0] pc_target_o,
   output logic stack_push_o,
   output logic stack_pop_o,
   output logic [20:0] push_addr_o,
   output logic working_register_load_o,
   output logic [7:0] working_register_o,
   output logic irq_enable_set_o,
   output logic ctx_restore_o,
   output logic standby_o,
   output logic watchdog_clear_o,
   output logic decimal_adjust_o,
   output logic soft_reset_o,
   output logic timeout_flag_o,
   output logic power_down_flag_o,
   output logic prescaler_clear_o,
   output logic [7:0] rmw_data_o,
   output logic prog_write_o
);
   cfd_ctl_if ctl ();
   cfd_pkg::cfd_state_t state_r, state_nxt;
   logic [7:0] lo_target_r;
   logic is_call_r;
   logic call_fast_r;
   logic [7:0] pins_sync;
   logic [1:0] cycles_r;
   logic [15:0] count_r;
   logic pc_load_nxt, push_nxt, pop_nxt, working_register_nxt, irq_nxt, ctx_nxt;
   logic standby_nxt, wdt_nxt, daw_nxt, reset_nxt, tblwr_nxt, retire_nxt;
   logic [20:0] target_nxt;
   logic [1:0] cycles_nxt;
   logic [15:0] w;
   logic take;

   // ==========================================================
   // Condition evaluation
   function automatic logic cond_true(input logic [2:0] cc, input logic z, input logic c,
                                      input logic v, input logic n);
      case (cc)
         cfd_pkg::CC_ZERO: cond_true = z;
         cfd_pkg::CC_NOT_ZERO: cond_true = !z;
         cfd_pkg::CC_CARRY: cond_true = c;
         cfd_pkg::CC_NOT_CARRY: cond_true = !c;
         cfd_pkg::CC_OVF: cond_true = v;
         cfd_pkg::CC_NOT_OVF: cond_true = !v;
         cfd_pkg::CC_NEG: cond_true = n;
         default: cond_true = !n;
      endcase
   endfunction

   // Word offset to byte displacement
   function automatic logic [20:0] word_disp(input logic [10:0] off);
      word_disp = {{9{off[10]}}, off, 1'b0};
   endfunction

   // ==========================================================
   // Submodules
   cfd_avmm_regs u_regs (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .ctl(ctl.regs)
   );

   cfd_pin_sync #(.WIDTH(cfd_pkg::PORT_W)) u_pins (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .async_i(port_pins_i),
      .sync_o(pins_sync)
   );

   assign ctl.timeout_flag = timeout_flag_o;
   assign ctl.power_down_flag = power_down_flag_o;
   assign ctl.prog_write = prog_write_o;
   assign ctl.state_code = state_r;
   assign ctl.last_cycles = cycles_r;
   assign ctl.instr_count = count_r;
   assign w = instr_word_i;
   assign take = instr_valid_i && ctl.decode_enable;

   // ==========================================================
   // Decode
   always_comb begin
      state_nxt = state_r;
      pc_load_nxt = 1'b0;
      target_nxt = '0;
      push_nxt = 1'b0;
      pop_nxt = 1'b0;
      working_register_nxt = 1'b0;
      irq_nxt = 1'b0;
      ctx_nxt = 1'b0;
      standby_nxt = 1'b0;
      wdt_nxt = 1'b0;
      daw_nxt = 1'b0;
      reset_nxt = 1'b0;
      tblwr_nxt = 1'b0;
      retire_nxt = 1'b0;
      cycles_nxt = 2'd1;
      case (state_r)
         cfd_pkg::ST_EXEC: begin
            if (take) begin
               retire_nxt = 1'b1;
               if (w[15:11] == cfd_pkg::OP_COND_BRANCH) begin
                  if (cond_true(w[10:8], flag_zero_i, flag_carry_i, flag_ovf_i, flag_neg_i)) begin
                     pc_load_nxt = 1'b1;
                     target_nxt = next_pc_i + word_disp({{3{w[7]}}, w[7:0]});
                  end
               end else if (w[15:11] == cfd_pkg::OP_REL_JUMP
                            || w[15:11] == cfd_pkg::OP_REL_CALL) begin
                  pc_load_nxt = 1'b1;
                  push_nxt = w[11];
                  target_nxt = next_pc_i + word_disp(w[10:0]);
               end else if (w[15:8] == cfd_pkg::OP_ABS_JUMP
                            || w[15:9] == cfd_pkg::OP_ABS_CALL) begin
                  retire_nxt = 1'b0;
                  state_nxt = cfd_pkg::ST_WORD2;
               end else if (w[15:12] == cfd_pkg::OP_SECOND_WORD) begin
                  cycles_nxt = 2'd1;
               end else if (w == cfd_pkg::OP_POP) begin
                  pop_nxt = 1'b1;
               end else if (w == cfd_pkg::OP_PUSH) begin
                  push_nxt = 1'b1;
               end else if (w[15:1] == cfd_pkg::OP_IRQ_RETURN) begin
                  pc_load_nxt = 1'b1;
                  target_nxt = stack_top_entry_i;
                  pop_nxt = 1'b1;
                  irq_nxt = 1'b1;
                  ctx_nxt = w[0];
               end else if (w[15:1] == cfd_pkg::OP_SUB_RETURN) begin
                  pc_load_nxt = 1'b1;
                  target_nxt = stack_top_entry_i;
                  pop_nxt = 1'b1;
                  ctx_nxt = w[0];
               end else if (w[15:8] == cfd_pkg::OP_LIT_RETURN) begin
                  pc_load_nxt = 1'b1;
                  target_nxt = stack_top_entry_i;
                  pop_nxt = 1'b1;
                  working_register_nxt = 1'b1;
               end else if (w == cfd_pkg::OP_STANDBY) begin
                  standby_nxt = 1'b1;
               end else if (w == cfd_pkg::OP_WDT_CLEAR) begin
                  wdt_nxt = 1'b1;
               end else if (w == cfd_pkg::OP_DEC_ADJUST) begin
                  daw_nxt = 1'b1;
               end else if (w == cfd_pkg::OP_SOFT_RESET) begin
                  reset_nxt = 1'b1;
               end else if (w[15:2] == cfd_pkg::OP_TABLE_WRITE) begin
                  tblwr_nxt = 1'b1;
               end
               if (pc_load_nxt) begin
                  cycles_nxt = 2'd2;
                  state_nxt = cfd_pkg::ST_FLUSH;
               end
            end
         end
         cfd_pkg::ST_WORD2: begin
            if (instr_valid_i) begin
               retire_nxt = 1'b1;
               cycles_nxt = 2'd2;
               state_nxt = cfd_pkg::ST_FLUSH;
               if (w[15:12] == cfd_pkg::OP_SECOND_WORD) begin
                  pc_load_nxt = 1'b1;
                  target_nxt = {w[11:0], lo_target_r, 1'b0};
                  push_nxt = is_call_r;
                  ctx_nxt = is_call_r && call_fast_r;
               end else begin
                  state_nxt = cfd_pkg::ST_EXEC;
               end
            end
         end
         cfd_pkg::ST_FLUSH: begin
            if (instr_valid_i) begin
               state_nxt = cfd_pkg::ST_EXEC;
            end
         end
         default: state_nxt = cfd_pkg::ST_EXEC;
      endcase
   end

   // ==========================================================
   // Sequencer state and first-word capture
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_r <= cfd_pkg::ST_EXEC;
         lo_target_r <= '0;
         is_call_r <= 1'b0;
         call_fast_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == cfd_pkg::ST_EXEC && state_nxt == cfd_pkg::ST_WORD2) begin
            lo_target_r <= w[7:0];
            is_call_r <= (w[15:9] == cfd_pkg::OP_ABS_CALL);
            call_fast_r <= w[8];
         end
      end
   end

   // ==========================================================
   // Registered control outputs
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pc_load_o <= 1'b0;
         pc_target_o <= '0;
         stack_push_o <= 1'b0;
         stack_pop_o <= 1'b0;
         push_addr_o <= '0;
         working_register_load_o <= 1'b0;
         working_register_o <= '0;
         irq_enable_set_o <= 1'b0;
         ctx_restore_o <= 1'b0;
         standby_o <= 1'b0;
         watchdog_clear_o <= 1'b0;
         decimal_adjust_o <= 1'b0;
         soft_reset_o <= 1'b0;
      end else begin
         pc_load_o <= pc_load_nxt;
         pc_target_o <= target_nxt;
         stack_push_o <= push_nxt;
         stack_pop_o <= pop_nxt;
         push_addr_o <= next_pc_i;
         working_register_load_o <= working_register_nxt;
         working_register_o <= w[7:0];
         irq_enable_set_o <= irq_nxt;
         ctx_restore_o <= ctx_nxt;
         standby_o <= standby_nxt;
         watchdog_clear_o <= wdt_nxt;
         decimal_adjust_o <= daw_nxt;
         soft_reset_o <= reset_nxt;
      end
   end

   // ==========================================================
   // Timeout and power-down flags
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         timeout_flag_o <= 1'b1;
         power_down_flag_o <= 1'b1;
      end else if (standby_nxt) begin
         timeout_flag_o <= 1'b1;
         power_down_flag_o <= 1'b0;
      end else if (wdt_nxt) begin
         timeout_flag_o <= 1'b1;
         power_down_flag_o <= 1'b1;
      end
   end

   // ==========================================================
   // Timer zero prescaler clear
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prescaler_clear_o <= 1'b0;
      end else begin
         prescaler_clear_o <= file_write_i && dest_file_i && ctl.prescaler_assigned
                              && file_addr_i == cfd_pkg::TIMER_ZERO_ADDR;
      end
   end

   // ==========================================================
   // Port read-modify-write source
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rmw_data_o <= '0;
      end else begin
         rmw_data_o <= pins_sync;
      end
   end

   // ==========================================================
   // Program memory write, held until terminated
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prog_write_o <= 1'b0;
      end else begin
         prog_write_o <= tblwr_nxt || (prog_write_o && !prog_write_done_i);
      end
   end

   // ==========================================================
   // Retired instruction count and cycle figure
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         count_r <= '0;
         cycles_r <= '0;
      end else if (retire_nxt) begin
         count_r <= count_r + 16'h0001;
         cycles_r <= cycles_nxt;
      end
   end
endmodule // cfd_decoder
`default_nettype wire

// file: sim/cfd_dec_checker.sv
// Concurrent checks on the decoder top ports.
// Assumes binding to cfd_decoder on sys_clk_i with reset_i.
`timescale 1ns/1ps
`default_nettype none
module cfd_dec_checker (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic instr_valid_i,
   input wire logic [20:0] next_pc_i,
   input wire logic file_write_i,
   input wire logic [11:0] file_addr_i,
   input wire logic dest_file_i,
   input wire logic [7:0] port_pins_i,
   input wire logic prog_write_done_i,
   input wire logic pc_load_o,
   input wire logic stack_push_o,
   input wire logic [20:0] push_addr_o,
   input wire logic working_register_load_o,
   input wire logic irq_enable_set_o,
   input wire logic standby_o,
   input wire logic watchdog_clear_o,
   input wire logic timeout_flag_o,
   input wire logic power_down_flag_o,
   input wire logic prescaler_clear_o,
   input wire logic [7:0] rmw_data_o,
   input wire logic prog_write_o
);
   // ==========
   // Clocking and age since reset
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [1:0] age_r;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   sequence s_done_seen;
      $past(prog_write_done_i) || $past(prog_write_done_i, 2);
   endsequence
   // ==========
   // Assertions
   pcload_cause_a: assert property (pc_load_o |-> $past(instr_valid_i))
      else $error("pc load without word");
   push_addr_a: assert property (stack_push_o |-> push_addr_o == $past(next_pc_i))
      else $error("push address wrong");
   sleep_flags_a: assert property (standby_o |-> ##[0:1] (timeout_flag_o && !power_down_flag_o))
      else $error("standby flags wrong");
   wdt_flags_a: assert property (watchdog_clear_o |-> ##[0:1] (timeout_flag_o && power_down_flag_o))
      else $error("watchdog flags wrong");
   presc_cause_a: assert property (prescaler_clear_o |-> $past(file_write_i && dest_file_i
      && file_addr_i == cfd_pkg::TIMER_ZERO_ADDR))
      else $error("prescaler clear without cause");
   rmw_pins_a: assert property (age_r == 2'h3 |-> rmw_data_o == $past(port_pins_i, 3))
      else $error("rmw data not pins");
   tw_hold_a: assert property ($fell(prog_write_o) |-> s_done_seen)
      else $error("table write ended early");
   irq_ret_a: assert property (irq_enable_set_o |-> pc_load_o)
      else $error("irq return without pc load");
   lit_ret_a: assert property (working_register_load_o |-> pc_load_o)
      else $error("literal return without pc load");
endmodule // cfd_dec_checker
bind cfd_decoder cfd_dec_checker i_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
   .instr_valid_i(instr_valid_i), .next_pc_i(next_pc_i), .file_write_i(file_write_i),
   .file_addr_i(file_addr_i), .dest_file_i(dest_file_i), .port_pins_i(port_pins_i),
   .prog_write_done_i(prog_write_done_i), .pc_load_o(pc_load_o), .stack_push_o(stack_push_o),
   .push_addr_o(push_addr_o), .working_register_load_o(working_register_load_o), .irq_enable_set_o(irq_enable_set_o),
   .standby_o(standby_o), .watchdog_clear_o(watchdog_clear_o), .timeout_flag_o(timeout_flag_o),
   .power_down_flag_o(power_down_flag_o), .prescaler_clear_o(prescaler_clear_o),
   .rmw_data_o(rmw_data_o), .prog_write_o(prog_write_o));
`default_nettype wire

// file: sim/cfd_stack_model.sv
// Return stack model on the far side of the decoder.
// Assumes push and pop pulses on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module cfd_stack_model (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [20:0] addr_i,
   output logic [20:0] top_o
);
   // ==========
   // Four entries, arbitrary start contents
   logic [20:0] mem_r [4];
   logic [1:0] sp_r;
   assign top_o = mem_r[sp_r];
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sp_r <= 2'h0;
         mem_r <= '{21'h01F0A4, 21'h00A3C2, 21'h1E0010, 21'h0004F6};
      end else if (push_i) begin
         sp_r <= sp_r + 2'h1;
         mem_r[sp_r + 2'h1] <= addr_i;
      end else if (pop_i) begin
         sp_r <= sp_r - 2'h1;
      end
   end
endmodule // cfd_stack_model
`default_nettype wire

// file: sim/cfd_decoder_tb.sv
// Self-checking bench for the control-flow decoder.
// Assumes the stack model as partner and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module cfd_decoder_tb;
   logic sys_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'h0, wr = 1'h0, iv = 1'h0, fw = 1'h0, fd = 1'h0, done = 1'h0;
   logic [31:0] wd = 32'h0, q, rdat;
   logic [15:0] iw = 16'h0;
   logic [3:0] flg = 4'h0, pat;
   logic [11:0] fa = 12'h0;
   logic [7:0] pins = 8'h0, nb, working_register, rmw;
   logic [20:0] npc = 21'h001000, stk, tgt, pa;
   wire logic [9:0] pl;
   logic wt, to, pd, pclr, pw;
   int n_errors = 0, tests_run = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   cfd_decoder i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .instr_word_i(iw), .instr_valid_i(iv), .next_pc_i(npc),
      .stack_top_entry_i(stk), .flag_zero_i(flg[0]), .flag_carry_i(flg[1]),
      .flag_ovf_i(flg[2]), .flag_neg_i(flg[3]), .file_write_i(fw), .file_addr_i(fa),
      .dest_file_i(fd), .port_pins_i(pins), .prog_write_done_i(done), .pc_load_o(pl[9]),
      .pc_target_o(tgt), .stack_push_o(pl[8]), .stack_pop_o(pl[7]), .push_addr_o(pa),
      .working_register_load_o(pl[6]), .working_register_o(working_register), .irq_enable_set_o(pl[5]),
      .ctx_restore_o(pl[4]), .standby_o(pl[3]), .watchdog_clear_o(pl[2]),
      .decimal_adjust_o(pl[1]), .soft_reset_o(pl[0]), .timeout_flag_o(to),
      .power_down_flag_o(pd), .prescaler_clear_o(pclr), .rmw_data_o(rmw), .prog_write_o(pw));
   cfd_stack_model i_stk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .push_i(pl[8]),
      .pop_i(pl[7]), .addr_i(pa), .top_o(stk));
   // ==========
   // Tasks
   task automatic give_verdict;
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, x);
      tests_run++;
      if (s !== x) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", nm, x, s);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk_i);
      {adr, wr, rd, wd} <= {a, w, ~w, d};
      for (i = 0; i < 20 && wt !== 1'h0; i++) @(posedge sys_clk_i);
      if (i == 20) begin
         n_errors++;
         give_verdict;
      end
      q = rdat;
      {wr, rd} <= 2'h0;
   endtask
   task automatic op(input logic [15:0] w1, input logic [9:0] e, input logic [20:0] t = 21'h0,
         input logic [9:0] m = 10'h3FF, input logic [15:0] w2 = 16'h0);
      @(posedge sys_clk_i);
      {iw, iv} <= {w1, 1'h1};
      if (w2 != 16'h0) begin
         @(posedge sys_clk_i);
         iw <= w2;
      end
      @(posedge sys_clk_i);
      iv <= 1'h0;
      #1;
      chk("pulses", pl & m, e & m);
      if (e[9]) chk("target", tgt, t);
      if (e[8]) chk("push_addr", pa, npc);
      if (e[6]) chk("working_register", working_register, w1[7:0]);
      @(posedge sys_clk_i);
      {iw, iv} <= 17'h1FFFF;
      @(posedge sys_clk_i);
      iv <= 1'h0;
      #1;
      chk("filler", pl, 10'h0);
   endtask
   task automatic fwr(input logic d, e);
      @(posedge sys_clk_i);
      {fw, fa, fd} <= {1'h1, cfd_pkg::TIMER_ZERO_ADDR, d};
      @(posedge sys_clk_i);
      fw <= 1'h0;
      #1;
      chk("presc", pclr, e);
   endtask
   // ==========
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      #1;
      chk("to_rst", {to, pd}, 2'h3);
      bus(1'h0, 4'h0, 32'h0);
      chk("ctrl_rst", q, 32'h2);
      bus(1'h1, 4'h0, 32'h3);
      bus(1'h0, 4'h0, 32'h0);
      chk("ctrl", q, 32'h3);
      bus(1'h0, 4'hC, 32'h0);
      chk("unmapped", q, 32'h0);
      for (int f = 0; f < 3; f++) begin
         pat = (f == 0) ? 4'h3 : (f == 1) ? 4'h5 : 4'hA;
         @(posedge sys_clk_i);
         flg <= pat;
         for (int c = 0; c < 8; c++) begin
            nb = c[0] ? 8'h80 : 8'h7F;
            op({5'h1C, c[2:0], nb}, {pat[c[2:1]] ^ c[0], 9'h0},
               npc + {{12{nb[7]}}, nb, 1'h0});
         end
      end
      op(16'hD7FF, 10'h200, npc - 21'h2);
      op(16'hDC00, 10'h300, npc - 21'h800);
      op(16'hEF12, 10'h200, 21'h068A24, 10'h3FF, 16'hF345);
      op(16'hED12, 10'h310, 21'h068A24, 10'h3FF, 16'hF345);
      op(16'h0005, 10'h100);
      op(16'h0006, 10'h080);
      op(16'h0011, 10'h2B0, stk);
      op(16'h0010, 10'h2A0, stk);
      op(16'h0013, 10'h290, stk);
      op(16'h0012, 10'h280, stk);
      op(16'h0CA5, 10'h2C0, stk);
      op(16'h0003, 10'h008);
      chk("sleep_flags", {to, pd}, 2'h2);
      op(16'h0004, 10'h004);
      chk("wdt_flags", {to, pd}, 2'h3);
      op(16'h0007, 10'h002);
      op(16'h0000, 10'h000);
      op(16'hF123, 10'h000);
      fwr(1'h1, 1'h1);
      fwr(1'h0, 1'h0);
      bus(1'h1, 4'h0, 32'h0);
      op(16'hD7FF, 10'h000);
      fwr(1'h1, 1'h0);
      bus(1'h1, 4'h0, 32'h3);
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk_i);
         pins <= k ? 8'hA5 : 8'h5A;
         repeat (3) @(posedge sys_clk_i);
         #1;
         chk("rmw", rmw, k ? 8'hA5 : 8'h5A);
      end
      op(16'h000C, 10'h000);
      bus(1'h0, 4'h4, 32'h0);
      chk("status_pw", {pw, q[2]}, 2'h3);
      @(posedge sys_clk_i);
      done <= 1'h1;
      @(posedge sys_clk_i);
      done <= 1'h0;
      @(posedge sys_clk_i);
      #1;
      chk("pw_end", pw, 1'h0);
      op(16'h00FF, 10'h001);
      give_verdict;
   end
endmodule // cfd_decoder_tb
`default_nettype wire
